// ==== verilog/dpu_pkg.sv ====
// constants, field layout and operation codes for the pointer update block
// assumes one core clock and a decoder that flags each pointer operation
//
// What this block does
// - each pointer has its own decrement select
// - resolve physical pointer first, then its direction
// - decrement select also sets auto-update direction
// - pointer one auto-updates on its data accesses
// - pointer one steps up, down, or holds
// - pointer zero auto-updates on its data accesses
// - pointer zero steps up, down, or holds
// - pointer one increment obeys its decrement bit
// - pointer zero increment obeys its decrement bit
// - signature select set steers table reads
// - signature select clear targets code memory
// - config register layout, offset, zero reset
// - auto-update works for direct and inverted forms
// - active select picks the referenced pointer
// - config bit two always reads zero
// - inverted prefix flips select, except indexed jump
// - both pointers always reachable at own offsets
package dpu_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int PTR_W  = 16;   // pointer width
    localparam int ADDR_W = 12;   // bus address width
    localparam int IDX_W  = 8;    // register index width

    // ****************************************************************
    // register indexes, byte address is four times the index
    // ****************************************************************
    localparam logic [7:0] IDX_PZ_LO = 8'h82;  // pointer_zero low
    localparam logic [7:0] IDX_PZ_HI = 8'h83;  // pointer_zero high
    localparam logic [7:0] IDX_PO_LO = 8'h84;  // pointer_one low
    localparam logic [7:0] IDX_PO_HI = 8'h85;  // pointer_one high
    localparam logic [7:0] IDX_CFG   = 8'hA2;  // pointer_config

    // ****************************************************************
    // pointer_config fields and reset
    // ****************************************************************
    localparam int B_SEL      = 0;   // active_ptr_sel
    localparam int B_ZERO_FIX = 2;   // always zero
    localparam int B_SIG      = 3;   // signature_select
    localparam int B_DOWN0    = 4;   // ptr_zero_down
    localparam int B_DOWN1    = 5;   // ptr_one_down
    localparam int B_STEP0    = 6;   // ptr_zero_autostep
    localparam int B_STEP1    = 7;   // ptr_one_autostep
    localparam logic [7:0] CFG_RST  = 8'h00;  // config reset
    localparam logic [7:0] CFG_WMSK = 8'hF9;  // storable bits
    localparam logic [15:0] PTR_RST = 16'h0000;  // pointer reset

    // ****************************************************************
    // bus responses
    // ****************************************************************
    localparam logic [1:0] RESP_OK  = 2'b00;  // okay
    localparam logic [1:0] RESP_ERR = 2'b10;  // slave error

    // ****************************************************************
    // operation kinds from the decoder
    // ****************************************************************
    typedef enum logic [2:0] {
        DPU_OP_NONE    = 3'b000,  // nothing
        DPU_OP_INC     = 3'b001,  // pointer increment instruction
        DPU_OP_XRD     = 3'b010,  // external data read
        DPU_OP_XWR     = 3'b011,  // external data write
        DPU_OP_TABLE   = 3'b100,  // code-table read
        DPU_OP_JMP     = 3'b101,  // indexed jump
        DPU_OP_IAP     = 3'b110   // in_application_programming access
    } dpu_op_t;

endpackage

// ==== verilog/dpu_step_if.sv ====
// carrier between the pointer owner and one stepper
// assumes a purely combinational stepper on the far side
`timescale 1ns/100ps
interface dpu_step_if;
    import dpu_pkg::*;
    logic [PTR_W-1:0] cur;   // pointer before update
    logic             en;    // step requested
    logic             down;  // step direction
    logic [PTR_W-1:0] nxt;   // pointer after update
    // stepper side
    modport stepper (input cur, input en, input down, output nxt);
    // owner side
    modport owner (output cur, output en, output down, input nxt);
endinterface

// ==== verilog/dpu_stepper.sv ====
// one-pointer up/down stepper
// assumes the owner registers the result
`timescale 1ns/100ps
module dpu_stepper (
    // step request and result
    dpu_step_if.stepper st
);
    import dpu_pkg::*;

    // ****************************************************************
    // step logic
    // ****************************************************************
    // natural 16-bit wrap on both directions
    always_comb begin
        if (!st.en) begin
            st.nxt = st.cur;                    // hold
        end else if (st.down) begin
            st.nxt = st.cur - 16'h0001;
        end else begin
            st.nxt = st.cur + 16'h0001;
        end
    end
endmodule

// ==== verilog/dpu_top.sv ====
// dual data pointer update logic with its register slave
// assumes decoder ops on the core clock, one-cycle op_valid pulses
`timescale 1ns/100ps
module dpu_top (
    // clock, reset, enable
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 ce,
    // write address channel
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [dpu_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]           awprot,
    // write data channel
    input  wire logic                 wvalid,
    output logic                      wready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    // write response channel
    output logic                      bvalid,
    input  wire logic                 bready,
    output logic [1:0]                bresp,
    // read address channel
    input  wire logic                 arvalid,
    output logic                      arready,
    input  wire logic [dpu_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]           arprot,
    // read data channel
    output logic                      rvalid,
    input  wire logic                 rready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    // decoder operations
    input  wire logic                 op_valid,
    input  wire dpu_pkg::dpu_op_t     op_kind,
    input  wire logic                 op_inverted,
    // memory access results
    output logic                      acc_valid,
    output logic [dpu_pkg::PTR_W-1:0] acc_addr,
    output logic                      acc_sig,
    output dpu_pkg::dpu_op_t          acc_kind
);
    import dpu_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0]       cfg_q;        // pointer_config
    logic [PTR_W-1:0] ptr_q [2];    // pointer_zero, pointer_one
    logic [PTR_W-1:0] ptr_nxt [2];  // stepper results
    logic [1:0]       step_en;      // per pointer step
    logic [1:0]       ptr_wr;       // per pointer bus write
    logic             aw_have_q;    // address held
    logic             w_have_q;     // data held
    logic [IDX_W-1:0] aw_idx_q;     // held write index
    logic [7:0]       wbyte_q;      // held write byte
    logic             wlane_q;      // low lane enabled
    logic             bvalid_q;     // response pending
    logic [1:0]       bresp_q;      // response code
    logic             rvalid_q;     // read data pending
    logic [31:0]      rdata_q;      // read data
    logic [1:0]       rresp_q;      // read code
    logic             acc_valid_q;  // access pulse
    logic [PTR_W-1:0] acc_addr_q;   // access address
    logic             acc_sig_q;    // signature target
    dpu_op_t          acc_kind_q;   // access kind

    // ****************************************************************
    // operation decode
    // ****************************************************************
    logic             op_fire;      // op taken this cycle
    logic             phys;         // physical pointer chosen
    logic             is_data;      // table or external access
    logic [PTR_W-1:0] sel_ptr;      // pointer value used
    logic [PTR_W-1:0] alt_ptr;      // pointer not selected
    logic             do_write;     // bus write this cycle
    logic             ar_fire;      // read address taken
    logic [IDX_W-1:0] ar_idx;       // read index

    assign op_fire = ce && op_valid;
    // pick the pointer: prefix flips select, jump ignores it
    assign phys = cfg_q[B_SEL] ^
                  (op_inverted && op_kind != DPU_OP_JMP);
    // accesses that may carry an automatic update
    assign is_data = (op_kind == DPU_OP_XRD) ||
                     (op_kind == DPU_OP_XWR) ||
                     (op_kind == DPU_OP_TABLE);
    assign sel_ptr = ptr_q[phys];
    assign alt_ptr = ptr_q[~cfg_q[B_SEL]];

    // ****************************************************************
    // per pointer stepping
    // ****************************************************************
    // index 0 uses zero bits, index 1 uses one bits
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_ptr
            dpu_step_if u_if ();
            logic up_bit;    // autostep for this pointer
            logic dn_bit;    // down select for this pointer
            assign up_bit = (g == 0) ? cfg_q[B_STEP0] : cfg_q[B_STEP1];
            assign dn_bit = (g == 0) ? cfg_q[B_DOWN0] : cfg_q[B_DOWN1];
            // increment or auto-update aimed at this pointer
            assign step_en[g] = op_fire && (phys == g[0]) &&
                ((op_kind == DPU_OP_INC) ||
                 (is_data && up_bit));
            assign u_if.cur  = ptr_q[g];
            assign u_if.en   = step_en[g];
            assign u_if.down = dn_bit;
            assign ptr_nxt[g] = u_if.nxt;
            dpu_stepper u_st (
                .st (u_if.stepper)
            );
        end
    endgenerate

    // ****************************************************************
    // register slave: write path
    // ****************************************************************
    // take each channel once, write when both are held
    assign awready  = ce && !aw_have_q && !bvalid_q;
    assign wready   = ce && !w_have_q && !bvalid_q;
    assign do_write = ce && aw_have_q && w_have_q && !bvalid_q;
    // which pointer the pending write touches
    assign ptr_wr[0] = do_write && wlane_q &&
        (aw_idx_q == IDX_PZ_LO || aw_idx_q == IDX_PZ_HI);
    assign ptr_wr[1] = do_write && wlane_q &&
        (aw_idx_q == IDX_PO_LO || aw_idx_q == IDX_PO_HI);
    // address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_idx_q  <= 8'h00;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;                     // held
                aw_idx_q  <= awaddr[IDX_W+1:2];
            end else if (do_write) begin
                aw_have_q <= 1'b0;                     // consumed
            end
        end
    end
    // data capture, only the low byte lane carries register data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wbyte_q  <= 8'h00;
            wlane_q  <= 1'b0;
        end else if (ce) begin
            if (wvalid && wready) begin
                w_have_q <= 1'b1;                      // held
                wbyte_q  <= wdata[7:0];
                wlane_q  <= wstrb[0];
            end else if (do_write) begin
                w_have_q <= 1'b0;                      // consumed
            end
        end
    end
    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OK;
        end else if (ce) begin
            if (do_write) begin
                bvalid_q <= 1'b1;
                if (aw_idx_q == IDX_CFG ||
                    (aw_idx_q >= IDX_PZ_LO && aw_idx_q <= IDX_PO_HI)) begin
                    bresp_q <= RESP_OK;
                end else begin
                    bresp_q <= RESP_ERR;               // unmapped
                end
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign bvalid = bvalid_q;
    assign bresp  = bresp_q;

    // ****************************************************************
    // configuration register
    // ****************************************************************
    // bits 2 and 1 never store, so they read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= CFG_RST;
        end else if (ce) begin
            if (do_write && wlane_q && aw_idx_q == IDX_CFG) begin
                cfg_q <= wbyte_q & CFG_WMSK;
            end
        end
    end

    // ****************************************************************
    // pointers
    // ****************************************************************
    // a bus write to a pointer overrides its step that cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ptr_q[0] <= PTR_RST;
            ptr_q[1] <= PTR_RST;
        end else if (ce) begin
            for (int i = 0; i < 2; i++) begin
                if (!ptr_wr[i]) begin
                    ptr_q[i] <= ptr_nxt[i];
                end else if (aw_idx_q[0]) begin
                    ptr_q[i][15:8] <= wbyte_q;
                end else begin
                    ptr_q[i][7:0] <= wbyte_q;
                end
            end
        end
    end

    // ****************************************************************
    // memory access outputs
    // ****************************************************************
    // address is the value before any update
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_valid_q <= 1'b0;
            acc_addr_q  <= PTR_RST;
            acc_sig_q   <= 1'b0;
            acc_kind_q  <= DPU_OP_NONE;
        end else if (ce) begin
            acc_valid_q <= op_valid;
            if (op_valid) begin
                acc_addr_q <= sel_ptr;
                acc_kind_q <= op_kind;
                acc_sig_q  <= cfg_q[B_SIG] &&
                    (op_kind == DPU_OP_TABLE || op_kind == DPU_OP_IAP);
            end
        end
    end

    assign acc_valid = acc_valid_q;
    assign acc_addr  = acc_addr_q;
    assign acc_sig   = acc_sig_q;
    assign acc_kind  = acc_kind_q;

    // ****************************************************************
    // register slave: read path
    // ****************************************************************
    assign arready = ce && !rvalid_q;
    assign ar_fire = arvalid && arready;
    assign ar_idx  = araddr[IDX_W+1:2];
    // one read in flight, data on the following cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OK;
        end else if (ce) begin
            if (ar_fire) begin
                rvalid_q <= 1'b1;
                rresp_q  <= RESP_OK;
                if (ar_idx == IDX_CFG) begin
                    rdata_q <= {24'h000000, cfg_q};
                end else if (ar_idx == IDX_PZ_LO || ar_idx == IDX_PO_LO) begin
                    rdata_q <= {24'h000000, ptr_q[ar_idx[2]][7:0]};
                end else if (ar_idx == IDX_PZ_HI || ar_idx == IDX_PO_HI) begin
                    rdata_q <= {24'h000000, ptr_q[ar_idx[2]][15:8]};
                end else begin
                    rdata_q <= 32'h0000_0000;          // unmapped
                    rresp_q <= RESP_ERR;
                end
            end else if (rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign rvalid = rvalid_q;
    assign rdata  = rdata_q;
    assign rresp  = rresp_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // increment aimed at pointer zero, direction from its bit
    property p_zero_inc;
        (op_fire && op_kind == DPU_OP_INC && !phys && !ptr_wr[0]) |=>
        ptr_q[0] == ($past(cfg_q[B_DOWN0]) ?
                     $past(ptr_q[0]) - 16'h0001 :
                     $past(ptr_q[0]) + 16'h0001);
    endproperty
    a_zero_inc: assert property (p_zero_inc)
        else $error("pointer zero increment wrong");
    // increment aimed at pointer one, direction from its bit
    property p_one_inc;
        (op_fire && op_kind == DPU_OP_INC && phys && !ptr_wr[1]) |=>
        ptr_q[1] == ($past(cfg_q[B_DOWN1]) ?
                     $past(ptr_q[1]) - 16'h0001 :
                     $past(ptr_q[1]) + 16'h0001);
    endproperty
    a_one_inc: assert property (p_one_inc)
        else $error("pointer one increment wrong");
    // data access on pointer zero with autostep clear holds it
    property p_zero_hold;
        (op_fire && is_data && !phys && !cfg_q[B_STEP0] &&
         !ptr_wr[0]) |=> $stable(ptr_q[0]);
    endproperty
    a_zero_hold: assert property (p_zero_hold)
        else $error("pointer zero moved without autostep");
    // data access on pointer one with autostep set steps it
    property p_one_auto;
        (op_fire && is_data && phys && cfg_q[B_STEP1] && !ptr_wr[1]) |=>
        ptr_q[1] == ($past(cfg_q[B_DOWN1]) ?
                     $past(ptr_q[1]) - 16'h0001 :
                     $past(ptr_q[1]) + 16'h0001);
    endproperty
    a_one_auto: assert property (p_one_auto)
        else $error("pointer one auto-update wrong");
    // access address is the value before the update
    sequence s_op_taken;
        op_fire;
    endsequence
    sequence s_acc_out(logic [PTR_W-1:0] v);
        acc_valid_q && acc_addr_q == v;
    endsequence
    property p_pre_value;
        s_op_taken |=> s_acc_out($past(sel_ptr));
    endproperty
    a_pre_value: assert property (p_pre_value)
        else $error("access did not use old pointer");
    // inverted form uses the pointer not selected
    property p_inverted;
        (op_fire && op_inverted && op_kind != DPU_OP_JMP) |=>
        acc_addr_q == $past(alt_ptr);
    endproperty
    a_inverted: assert property (p_inverted)
        else $error("inverted form chose wrong pointer");
    // signature select steers table and programming accesses
    property p_sig_on;
        (op_fire && cfg_q[B_SIG] &&
         (op_kind == DPU_OP_TABLE || op_kind == DPU_OP_IAP)) |=> acc_sig_q;
    endproperty
    a_sig_on: assert property (p_sig_on)
        else $error("signature target missed");
    // signature select clear keeps code memory
    property p_sig_off;
        (op_fire && !cfg_q[B_SIG]) |=> !acc_sig_q;
    endproperty
    a_sig_off: assert property (p_sig_off)
        else $error("signature target without select");
    // config reads show zero in bit two and the live select
    property p_cfg_read;
        (ar_fire && ar_idx == IDX_CFG) |=>
        rvalid_q && !rdata_q[B_ZERO_FIX] && !rdata_q[1] &&
        rdata_q[B_SEL] == $past(cfg_q[B_SEL]);
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("config read wrong");
    // a complete write is answered within three cycles
    property p_write_resp;
        (ce && awvalid && awready && wvalid && wready) |=>
        ##[0:2] bvalid_q;
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write not answered");
endmodule

// ==== bench/dpu_dec_model.sv ====
// decoder partner model: one op pulse per call on the core clock
// assumes the block under test samples ops at the rising edge
`timescale 1ns/100ps
module dpu_dec_model
    import dpu_pkg::*;
(
    // core clock
    input  wire logic        aclk,
    // op strobe towards the block
    output logic             op_valid,
    output dpu_pkg::dpu_op_t op_kind,
    output logic             op_inverted
);
    // idle values from time zero
    initial begin
        op_valid    = 1'b0;
        op_kind     = DPU_OP_NONE;
        op_inverted = 1'b0;
    end
    // one-cycle pulse; form flag is flipped once the pulse is over
    task automatic send(input dpu_op_t k, input logic i);
        @(posedge aclk);
        op_valid    <= 1'b1;
        op_kind     <= k;
        op_inverted <= i;
        @(posedge aclk);
        op_valid    <= 1'b0;
        op_inverted <= ~i;
    endtask
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the pointer update block
// assumes one 20 MHz core clock and a register model kept in integers
`timescale 1ns/100ps
module tb_top;
    import dpu_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        acc_valid, acc_sig, op_valid, op_inverted;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [15:0] acc_addr;
    dpu_op_t     acc_kind, op_kind;
    int          bad_count, samples_checked, cfg, p[2];
    dpu_top u_dpu_top (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .op_valid(op_valid), .op_kind(op_kind),
        .op_inverted(op_inverted), .acc_valid(acc_valid),
        .acc_addr(acc_addr), .acc_sig(acc_sig), .acc_kind(acc_kind));
    dpu_dec_model u_dpu_dec_model (.aclk(aclk), .op_valid(op_valid),
        .op_kind(op_kind), .op_inverted(op_inverted));
    // core clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // compare of register answers, response code on top
    task automatic chk_reg(input logic [33:0] g, input logic [33:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %0t: reg %h exp %h", $time, g, e);
        end
    endtask
    // compare of access outputs
    task automatic chk_acc(input logic [20:0] g, input logic [20:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %0t: access %h exp %h", $time, g, e);
        end
    endtask
    // bus write, readiness sampled mid-cycle, released after the edge
    task automatic wx(input logic [7:0] ix, input logic [7:0] d,
                      input logic [1:0] er);
        logic ta, tw, da, dw;
        logic [1:0] r;
        logic [7:0] k;
        da = 1'b0;
        dw = 1'b0;
        @(posedge aclk);
        awaddr  <= {2'b00, ix, 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(da && dw)) begin
            @(negedge aclk);
            ta = awready & ~da;
            tw = wready & ~dw;
            @(posedge aclk);
            if (ta) begin
                awvalid <= 1'b0;
                da = 1'b1;
            end
            if (tw) begin
                wvalid <= 1'b0;
                dw = 1'b1;
            end
        end
        ta = 1'b0;
        while (!ta) begin
            @(negedge aclk);
            ta = bvalid;
            r = bresp;
            @(posedge aclk);
        end
        bready <= 1'b0;
        chk_reg({r, 32'h0}, {er, 32'h0});
        if (ix == IDX_CFG) cfg = d & 8'hF9;
        k = ix - IDX_PZ_LO;
        if (k < 8'h04 && k[0]) p[k[1]][15:8] = d;
        if (k < 8'h04 && !k[0]) p[k[1]][7:0] = d;
    endtask
    // bus read and compare with the model
    task automatic rx(input logic [7:0] ix, input logic [31:0] e,
                      input logic [1:0] er);
        logic t;
        logic [33:0] v;
        t = 1'b0;
        @(posedge aclk);
        araddr  <= {2'b00, ix, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!t) begin
            @(negedge aclk);
            t = arready;
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        t = 1'b0;
        while (!t) begin
            @(negedge aclk);
            t = rvalid;
            v = {rresp, rdata};
            @(posedge aclk);
        end
        rready <= 1'b0;
        chk_reg(v, {er, e});
    endtask
    // both pointers through their own byte registers
    task automatic chkp;
        for (int j = 0; j < 4; j++)
            rx(8'(IDX_PZ_LO + j), 32'((p[j/2] >> (8*(j%2))) & 255),
               RESP_OK);
    endtask
    // one decoder op against the integer model
    task automatic op(input dpu_op_t k, input logic i);
        int ph;
        logic s;
        ph = (cfg & 1) ^ int'(i && k != DPU_OP_JMP);
        s = (k == DPU_OP_TABLE || k == DPU_OP_IAP) && cfg[3];
        u_dpu_dec_model.send(k, i);
        @(negedge aclk);
        chk_acc({acc_valid, acc_sig, acc_kind, acc_addr},
                {1'b1, s, k, p[ph][15:0]});
        if (k == DPU_OP_INC || (k inside {DPU_OP_XRD, DPU_OP_XWR,
            DPU_OP_TABLE} && cfg[6+ph]))
            p[ph] = (cfg[4+ph] ? p[ph] - 1 : p[ph] + 1)
                    & 16'hFFFF;
    endtask
    // verdict and end of run
    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #2000000;
        bad_count++;
        finish_test();
    end
    // main sequence
    initial begin
        {aresetn, awvalid, wvalid, arvalid, bready, rready} = 6'h00;
        {awaddr, araddr, wdata, cfg, p[0], p[1]} = '0;
        {bad_count, samples_checked} = '0;
        void'($urandom(57));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rx(IDX_CFG, 32'h0, RESP_OK);
        chkp();
        wx(IDX_CFG, 8'hFF, RESP_OK);
        rx(IDX_CFG, 32'hF9, RESP_OK);
        wx(8'h86, 8'h5A, RESP_ERR);
        rx(8'h86, 32'h0, RESP_ERR);
        for (int n = 0; n < 224; n++) begin
            if (n % 7 == 0) wx(IDX_CFG, 8'($urandom), RESP_OK);
            if (n % 7 == 0) wx(8'(IDX_PZ_LO + n % 4),
                $urandom_range(0, 1) ? 8'hFF : 8'h00, RESP_OK);
            op(dpu_op_t'(n % 7), 1'($urandom));
            chkp();
        end
        finish_test();
    end
endmodule
